// ### rtl/pmcfg_cfg.svh
// Purpose: addresses, field positions, reset values and timing counts of the
//          power-management pin and flag registers
// Assumes: 8-bit special-function register space, 40 MHz core clock
// Notes:   definitions only
`ifndef PMCFG_CFG_SVH
`define PMCFG_CFG_SVH

// ============================================================
// register addresses
`define PMCFG_ADDR_KEY      8'hC1
`define PMCFG_ADDR_ENABLES  8'hEC
`define PMCFG_ADDR_BATSW    8'hF5
`define PMCFG_ADDR_FLAGS    8'hF8
`define PMCFG_ADDR_PINCFG   8'hFF

// ============================================================
// bit addresses of the flag register
`define PMCFG_BIT_FLAGS_LO  8'hF8
`define PMCFG_BIT_FLAGS_HI  8'hFF

// ============================================================
// field positions
`define PMCFG_PIN_CALEN     7
`define PMCFG_PIN_FSEL_HI   6
`define PMCFG_PIN_FSEL_LO   5
`define PMCFG_PIN_IRQ2_HI   3
`define PMCFG_PIN_IRQ2_LO   1
`define PMCFG_PIN_IRQ1EN    0
`define PMCFG_FLG_RESTORED  7
`define PMCFG_FLG_SUMMARY   6
`define PMCFG_FLG_SAG       5
`define PMCFG_FLG_RSVD      4
`define PMCFG_FLG_CONVMON   3
`define PMCFG_FLG_BATMON    2
`define PMCFG_FLG_BATSW     1
`define PMCFG_FLG_DCLOW     0

// ============================================================
// reset values and masks
`define PMCFG_RST_PINCFG    8'h00
`define PMCFG_RST_FLAGS     8'h00
`define PMCFG_RST_BATSW     8'h00
`define PMCFG_RST_ENABLES   8'h00
`define PMCFG_RST_KEY       8'h00
`define PMCFG_PIN_MASK      8'hEF
`define PMCFG_EVT_MASK      8'hAF
`define PMCFG_BATSW_MASK    8'h03
`define PMCFG_UNLOCK_KEY    8'hEA

// ============================================================
// calibration output timing
`define PMCFG_CLK_HZ        40000000
`define PMCFG_CAL_F0_HZ     1
`define PMCFG_CAL_F1_HZ     512
`define PMCFG_CAL_F2_HZ     500
`define PMCFG_CAL_F3_HZ     16384
`define PMCFG_HALF_CYC(f)   (`PMCFG_CLK_HZ / (2 * (f)))

`endif

// ### rtl/pmcfg_pkg.sv
// Purpose: types shared by the power-management register bank
// Assumes: constants live in pmcfg_cfg.svh
// Notes:   encodings follow the register fields bit for bit
package pmcfg_pkg;

  // ============================================================
  // calibration frequency select
  typedef enum logic [1:0] {
    PMCFG_CAL_1HZ    = 2'b00,
    PMCFG_CAL_512HZ  = 2'b01,
    PMCFG_CAL_500HZ  = 2'b10,
    PMCFG_CAL_16KHZ  = 2'b11
  } pmcfg_cal_sel_t;

  // ============================================================
  // battery switchover policy
  typedef enum logic [1:0] {
    PMCFG_SW_LOW_MAIN = 2'b00,
    PMCFG_SW_LOW_DC   = 2'b01,
    PMCFG_SW_OFF_A    = 2'b10,
    PMCFG_SW_OFF_B    = 2'b11
  } pmcfg_policy_t;

endpackage : pmcfg_pkg

// ### rtl/pmcfg_cal_gen.sv
// Purpose: square-wave calibration clock for the shared calibration pin
// Assumes: half periods given in core clock cycles, each at least 1
// Notes:   restarts its count whenever the select changes or it is off
`timescale 1ns/1ps
`default_nettype none

module pmcfg_cal_gen
  import pmcfg_pkg::*;
#(
  parameter int unsigned HALF0 = 20000000,
  parameter int unsigned HALF1 = 39062,
  parameter int unsigned HALF2 = 40000,
  parameter int unsigned HALF3 = 1220
) (
  input  wire logic           clk_sys,   // core clock
  input  wire logic           rstn,      // async reset, active low
  input  wire logic           enable,    // calibration output on
  input  wire pmcfg_cal_sel_t sel,       // frequency select
  output logic                cal_q      // square wave
);

  logic [24:0]    cnt_q;
  logic [24:0]    cnt_d;
  logic           cal_d;
  pmcfg_cal_sel_t sel_q;
  pmcfg_cal_sel_t sel_d;
  logic [24:0]    limit;

  // ============================================================
  // next state
  always_comb begin
    case (sel)
      PMCFG_CAL_1HZ:   limit = 25'(HALF0 - 1);
      PMCFG_CAL_512HZ: limit = 25'(HALF1 - 1);
      PMCFG_CAL_500HZ: limit = 25'(HALF2 - 1);
      PMCFG_CAL_16KHZ: limit = 25'(HALF3 - 1);
      default:         limit = 25'(HALF0 - 1);
    endcase
    sel_d = sel;
    cnt_d = cnt_q;
    cal_d = cal_q;
    // a select change restarts the half period and drives the wave low at once, cutting short a high phase in progress
    if (!enable || (sel != sel_q)) begin
      cnt_d = '0;
      cal_d = 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_d = '0;
      cal_d = ~cal_q;
    end else begin
      cnt_d = cnt_q + 25'h0000001;
    end
  end

  // ============================================================
  // registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      cal_q <= 1'b0;
      sel_q <= PMCFG_CAL_1HZ;
    end else begin
      cnt_q <= cnt_d;
      cal_q <= cal_d;
      sel_q <= sel_d;
    end
  end

endmodule // pmcfg_cal_gen

`default_nettype wire

// ### rtl/pmcfg_regs.sv
// Purpose: power-management pin configuration, event flags and switchover policy
// Assumes: core drives sfr_wr/bit_wr as one-cycle strobes on clk_sys;
//          monitor inputs are asynchronous levels or pulses of two or more cycles
// Notes:   reads are registered, data appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "pmcfg_cfg.svh"

// Overview of operation
// - calibration pin carries the selected calibration clock while bit 7 is set.
// - bits 6..5 pick 1 Hz, 512 Hz, 500 Hz or 16.384 kHz calibration clock.
// - pin configuration writes take effect only while the key register holds 0xEA.
// - supply-restored flag sets when switched supply returns from battery to main.
// - summary flag sets whenever an enabled power event occurs.
// - sag flag sets on a sag report from the metering logic.
// - converter monitor flag sets on threshold change or new measurement.
// - battery monitor flag sets on low battery or battery measurement ready.
// - switchover flag sets when switched supply moves from main to battery.
// - dc-input-low flag sets when the sense input falls below 1.2 V.
// - flags are bit-addressable at 0xF8..0xFF and reset to zero.
// - bits 1..0 choose switchover on low main, low main or dc, or disabled.
// - each event has an enable; only enabled events raise the summary flag.
module pmcfg_regs
  import pmcfg_pkg::*;
#(
  parameter int unsigned CAL_HALF0 = `PMCFG_HALF_CYC(`PMCFG_CAL_F0_HZ),
  parameter int unsigned CAL_HALF1 = `PMCFG_HALF_CYC(`PMCFG_CAL_F1_HZ),
  parameter int unsigned CAL_HALF2 = `PMCFG_HALF_CYC(`PMCFG_CAL_F2_HZ),
  parameter int unsigned CAL_HALF3 = `PMCFG_HALF_CYC(`PMCFG_CAL_F3_HZ)
) (
  input  wire logic       clk_sys,               // core clock, 40 MHz
  input  wire logic       rstn,                  // async reset, active low
  input  wire logic [7:0] sfr_addr,              // byte register address
  input  wire logic       sfr_wr,                // byte write strobe
  input  wire logic       sfr_rd,                // byte read strobe
  input  wire logic [7:0] sfr_wdata,             // byte write data
  output logic      [7:0] sfr_rdata,             // byte read data, registered
  input  wire logic [7:0] bit_addr,              // bit address
  input  wire logic       bit_wr,                // bit write strobe
  input  wire logic       bit_rd,                // bit read strobe
  input  wire logic       bit_wdata,             // bit write value
  output logic            bit_rdata,             // bit read value, registered
  input  wire logic       on_battery,            // switched supply fed from battery
  input  wire logic       sag_event,             // metering sag report
  input  wire logic       dc_change_event,       // dc input moved by change threshold
  input  wire logic       dc_meas_ready,         // dc input measurement ready
  input  wire logic       battery_low,           // battery under low threshold
  input  wire logic       battery_meas_ready,    // battery measurement ready
  input  wire logic       dc_input_low,          // dc sense input under 1.2 V
  output logic            cal_out,               // calibration clock to pin
  output logic            cal_out_oe,            // calibration pin driven
  output logic            second_irq_gpio_en,    // second irq pin as gpio
  output logic            battery_ctrl_en,       // second irq pin as battery control
  output logic            second_irq_input_en,   // second irq input enabled
  output logic            first_irq_pin_enable,  // first irq input enabled
  output logic            switch_on_dc_low,      // switchover also on low dc input
  output logic            switchover_disable     // switchover disabled
);

  localparam int NEV = 7;

  // ============================================================
  // decoding used by byte and bit paths
  function automatic logic is_flag_bit(input logic [7:0] a);
    is_flag_bit = (a >= `PMCFG_BIT_FLAGS_LO) && (a <= `PMCFG_BIT_FLAGS_HI);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // ============================================================
  // register state
  logic [7:0]     pin_q;
  logic [7:0]     pin_d;
  logic [7:0]     flags_q;
  logic [7:0]     flags_d;
  logic [7:0]     batsw_q;
  logic [7:0]     batsw_d;
  logic [7:0]     en_q;
  logic [7:0]     en_d;
  logic [7:0]     key_q;
  logic [7:0]     key_d;
  logic [7:0]     rdata_d;
  logic           brdata_d;
  logic           unlocked;
  logic [7:0]     set_vec;
  logic [7:0]     wr_val;
  logic [7:0]     wr_mask;

  // ============================================================
  // monitor input synchronisers and edge detect
  logic [NEV-1:0] raw;
  logic [NEV-1:0] sync1_q;
  logic [NEV-1:0] sync2_q;
  logic [NEV-1:0] prev_q;
  logic [NEV-1:0] rise;
  logic           restored;

  assign raw = {dc_input_low, battery_meas_ready, battery_low, dc_meas_ready,
                dc_change_event, sag_event, on_battery};

  genvar gi;
  generate
    for (gi = 0; gi < NEV; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          prev_q[gi]  <= 1'b0;
        end else begin
          sync1_q[gi] <= raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          prev_q[gi]  <= sync2_q[gi];
        end
      end
      assign rise[gi] = sync2_q[gi] & ~prev_q[gi];
    end
  endgenerate

  // falling edge of on_battery means the main supply is back
  assign restored = ~sync2_q[0] & prev_q[0];

  // ============================================================
  // event sets
  always_comb begin
    set_vec = 8'h00;
    set_vec[`PMCFG_FLG_RESTORED] = restored;
    set_vec[`PMCFG_FLG_SAG]      = rise[1];
    set_vec[`PMCFG_FLG_CONVMON]  = rise[2] | rise[3];
    set_vec[`PMCFG_FLG_BATMON]   = rise[4] | rise[5];
    set_vec[`PMCFG_FLG_BATSW]    = rise[0];
    set_vec[`PMCFG_FLG_DCLOW]    = rise[6];
    // summary sees the event itself, so a same-cycle clear of the source flag
    // cannot hide it
    set_vec[`PMCFG_FLG_SUMMARY]  = |(set_vec & en_q & `PMCFG_EVT_MASK);
  end

  assign unlocked = (key_q == `PMCFG_UNLOCK_KEY);

  // ============================================================
  // next register values
  always_comb begin
    pin_d   = pin_q;
    batsw_d = batsw_q;
    en_d    = en_q;
    key_d   = key_q;
    wr_val  = 8'h00;
    wr_mask = 8'h00;
    if (sfr_wr) begin
      if (hit(sfr_addr, `PMCFG_ADDR_PINCFG) && unlocked) begin
        pin_d = sfr_wdata & `PMCFG_PIN_MASK;
      end
      if (hit(sfr_addr, `PMCFG_ADDR_KEY)) begin
        key_d = sfr_wdata;
      end
      if (hit(sfr_addr, `PMCFG_ADDR_ENABLES)) begin
        en_d = sfr_wdata & `PMCFG_EVT_MASK;
      end
      if (hit(sfr_addr, `PMCFG_ADDR_BATSW)) begin
        batsw_d = sfr_wdata & `PMCFG_BATSW_MASK;
      end
      if (hit(sfr_addr, `PMCFG_ADDR_FLAGS)) begin
        wr_val  = sfr_wdata;
        wr_mask = 8'hFF;
      end
    end else if (bit_wr && is_flag_bit(bit_addr)) begin
      wr_mask[bit_addr[2:0]] = 1'b1;
      wr_val[bit_addr[2:0]]  = bit_wdata;
    end
    // hardware set wins over a software clear in the same cycle
    flags_d = ((flags_q & ~wr_mask) | (wr_val & wr_mask) | set_vec)
              & ~(8'h01 << `PMCFG_FLG_RSVD);
  end

  // ============================================================
  // read mux
  always_comb begin
    rdata_d  = sfr_rdata;
    brdata_d = bit_rdata;
    if (sfr_rd) begin
      case (sfr_addr)
        `PMCFG_ADDR_PINCFG:  rdata_d = pin_q;
        `PMCFG_ADDR_FLAGS:   rdata_d = flags_q;
        `PMCFG_ADDR_BATSW:   rdata_d = batsw_q;
        `PMCFG_ADDR_ENABLES: rdata_d = en_q;
        `PMCFG_ADDR_KEY:     rdata_d = key_q;
        default:             rdata_d = 8'h00;
      endcase
    end
    if (bit_rd) begin
      brdata_d = is_flag_bit(bit_addr) ? flags_q[bit_addr[2:0]] : 1'b0;
    end
  end

  // ============================================================
  // registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_q     <= `PMCFG_RST_PINCFG;
      flags_q   <= `PMCFG_RST_FLAGS;
      batsw_q   <= `PMCFG_RST_BATSW;
      en_q      <= `PMCFG_RST_ENABLES;
      key_q     <= `PMCFG_RST_KEY;
      sfr_rdata <= 8'h00;
      bit_rdata <= 1'b0;
    end else begin
      pin_q     <= pin_d;
      flags_q   <= flags_d;
      batsw_q   <= batsw_d;
      en_q      <= en_d;
      key_q     <= key_d;
      sfr_rdata <= rdata_d;
      bit_rdata <= brdata_d;
    end
  end

  // ============================================================
  // decoded control outputs, registered from the next values; cal_out_oe is registered from the current pin_q
  logic irq2_gpio_d;
  logic battery_control_input_d;
  logic irq2_in_d;
  logic sw_dc_d;
  logic sw_off_d;

  always_comb begin
    irq2_gpio_d = pin_d[2:1] == 2'b00;
    battery_control_input_d     = pin_d[2:1] == 2'b01;
    irq2_in_d   = pin_d[3:2] == 2'b11;
    case (pmcfg_policy_t'(batsw_d[1:0]))
      PMCFG_SW_LOW_MAIN: begin
        sw_dc_d  = 1'b0;
        sw_off_d = 1'b0;
      end
      PMCFG_SW_LOW_DC: begin
        sw_dc_d  = 1'b1;
        sw_off_d = 1'b0;
      end
      default: begin
        sw_dc_d  = 1'b0;
        sw_off_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      second_irq_gpio_en   <= 1'b1;
      battery_ctrl_en      <= 1'b0;
      second_irq_input_en  <= 1'b0;
      first_irq_pin_enable <= 1'b0;
      switch_on_dc_low     <= 1'b0;
      switchover_disable   <= 1'b0;
      cal_out_oe           <= 1'b0;
    end else begin
      second_irq_gpio_en   <= irq2_gpio_d;
      battery_ctrl_en      <= battery_control_input_d;
      second_irq_input_en  <= irq2_in_d;
      first_irq_pin_enable <= pin_d[`PMCFG_PIN_IRQ1EN];
      switch_on_dc_low     <= sw_dc_d;
      switchover_disable   <= sw_off_d;
      cal_out_oe           <= pin_q[`PMCFG_PIN_CALEN];
    end
  end

  // ============================================================
  // calibration clock
  pmcfg_cal_gen #(
    .HALF0 (CAL_HALF0),
    .HALF1 (CAL_HALF1),
    .HALF2 (CAL_HALF2),
    .HALF3 (CAL_HALF3)
  ) u_cal (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .enable  (pin_q[`PMCFG_PIN_CALEN]),
    .sel     (pmcfg_cal_sel_t'(pin_q[`PMCFG_PIN_FSEL_HI:`PMCFG_PIN_FSEL_LO])),
    .cal_q   (cal_out)
  );

endmodule // pmcfg_regs

`default_nettype wire

// ### verif/pmcfg_regs_assertions.sv
// Purpose: port-level checks on the power-management register bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   mirrors the key register from bus writes to judge pin writes
`timescale 1ns/1ps
`default_nettype none
`include "pmcfg_cfg.svh"

module pmcfg_regs_checker (
  input wire logic       clk_sys,              // core clock
  input wire logic       rstn,                 // reset, active low
  input wire logic [7:0] sfr_addr,             // byte address
  input wire logic       sfr_wr,               // byte write
  input wire logic       sfr_rd,               // byte read
  input wire logic [7:0] sfr_wdata,            // write data
  input wire logic [7:0] sfr_rdata,            // read data
  input wire logic [7:0] bit_addr,             // bit address
  input wire logic       bit_rd,               // bit read
  input wire logic       bit_rdata,            // bit read data
  input wire logic       cal_out,              // calibration wave
  input wire logic       cal_out_oe,           // calibration pin driven
  input wire logic       second_irq_gpio_en,   // pin as gpio
  input wire logic       battery_ctrl_en,      // pin as battery control
  input wire logic       second_irq_input_en,  // second irq on
  input wire logic       first_irq_pin_enable, // first irq on
  input wire logic       switch_on_dc_low,     // policy 01
  input wire logic       switchover_disable    // policy 1x
);
  // ==========================================================
  // key mirror
  logic [7:0] key_q;
  logic [7:0] key_d;
  always_comb begin
    key_d = (sfr_wr && sfr_addr == `PMCFG_ADDR_KEY) ? sfr_wdata : key_q;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) key_q <= 8'h00;
    else key_q <= key_d;
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_pin_wr;
    sfr_wr && sfr_addr == `PMCFG_ADDR_PINCFG;
  endsequence
  sequence s_open_pin_wr;
    s_pin_wr ##0 key_q == `PMCFG_UNLOCK_KEY;
  endsequence

  a_pin_oe_follow: assert property (
    s_open_pin_wr |-> ##2 (cal_out_oe == $past(sfr_wdata[7], 2)))
    else $error("calibration enable does not follow pin write");
  a_cal_quiet_off: assert property (
    !cal_out_oe && !$past(cal_out_oe) |-> !cal_out)
    else $error("calibration wave active while pin released");
  a_locked_write_ignored: assert property (
    s_pin_wr ##0 key_q != `PMCFG_UNLOCK_KEY |=> $stable({second_irq_gpio_en,
      battery_ctrl_en, second_irq_input_en, first_irq_pin_enable}))
    else $error("locked pin write changed outputs");
  a_pin_decode_ok: assert property (
    s_open_pin_wr |=> first_irq_pin_enable == $past(sfr_wdata[0])
      && second_irq_gpio_en == ($past(sfr_wdata[2:1]) == 2'b00)
      && battery_ctrl_en == ($past(sfr_wdata[2:1]) == 2'b01)
      && second_irq_input_en == ($past(sfr_wdata[3:2]) == 2'b11))
    else $error("pin function decode wrong");
  a_policy_decode_ok: assert property (
    sfr_wr && sfr_addr == `PMCFG_ADDR_BATSW |=>
      switch_on_dc_low == ($past(sfr_wdata[1:0]) == 2'b01)
      && switchover_disable == $past(sfr_wdata[1]))
    else $error("switchover policy decode wrong");
  a_flag4_bit_zero: assert property (
    bit_rd && bit_addr == 8'hFC |=> !bit_rdata)
    else $error("flag bit 4 read as one");
  a_flag4_byte_zero: assert property (
    sfr_rd && sfr_addr == `PMCFG_ADDR_FLAGS |=> !sfr_rdata[4])
    else $error("flag byte bit 4 read as one");
  a_batsw_rsvd_zero: assert property (
    sfr_rd && sfr_addr == `PMCFG_ADDR_BATSW |=> sfr_rdata[7:2] == 6'h00)
    else $error("switchover reserved bits not zero");
  a_rdata_holds: assert property (
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
endmodule // pmcfg_regs_checker

bind pmcfg_regs pmcfg_regs_checker i_pmcfg_regs_checker (
  .clk_sys, .rstn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
  .bit_addr, .bit_rd, .bit_rdata, .cal_out, .cal_out_oe, .second_irq_gpio_en,
  .battery_ctrl_en, .second_irq_input_en, .first_irq_pin_enable,
  .switch_on_dc_low, .switchover_disable);
`default_nettype wire

// ### verif/tb_pmcfg_regs.sv
// Purpose: self-checking bench for the power-management register bank
// Assumes: short calibration half periods 4, 3, 5, 2 cycles
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none

module tb_pmcfg_regs;
  localparam int unsigned HALF [4] = '{4, 3, 5, 2};
  localparam int          FLAG [7] = '{0, 1, 2, 3, 2, 5, 3};
  logic       clk_sys;
  logic       rstn      = 1'b0;
  logic [7:0] sfr_addr  = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] bit_addr  = 8'h00;
  logic       sfr_wr    = 1'b0;
  logic       sfr_rd    = 1'b0;
  logic       bit_wr    = 1'b0;
  logic       bit_rd    = 1'b0;
  logic       bit_wdata = 1'b0;
  logic [6:0] ev        = 7'h00;
  logic [7:0] sfr_rdata;
  logic       bit_rdata, cal_out, cal_out_oe, gpio_en, bctl_en;
  logic       irq2_en, irq1_en, dc_low_sw, sw_off;
  int         miscompares = 0;
  int         comparisons = 0;
  int         cycles      = 0;

  pmcfg_regs #(.CAL_HALF0(4), .CAL_HALF1(3), .CAL_HALF2(5), .CAL_HALF3(2)) i_pmcfg_regs (
    .clk_sys(clk_sys), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_rd(bit_rd), .bit_wdata(bit_wdata),
    .bit_rdata(bit_rdata), .on_battery(ev[1]), .sag_event(ev[5]),
    .dc_change_event(ev[3]), .dc_meas_ready(ev[6]), .battery_low(ev[2]),
    .battery_meas_ready(ev[4]), .dc_input_low(ev[0]), .cal_out(cal_out),
    .cal_out_oe(cal_out_oe), .second_irq_gpio_en(gpio_en), .battery_ctrl_en(bctl_en),
    .second_irq_input_en(irq2_en), .first_irq_pin_enable(irq1_en),
    .switch_on_dc_low(dc_low_sw), .switchover_disable(sw_off));

  // ==========================================================
  // clock, timeout, verdict
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("BAD %0t ns: run too long", $time);
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // bus helpers
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    tick();
    sfr_wr = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    tick();
    sfr_addr = a;
    sfr_rd   = 1'b1;
    tick();
    sfr_rd = 1'b0;
    check(sfr_rdata, exp);
  endtask
  task automatic bwr(input int n, input logic v);
    tick();
    bit_addr  = 8'hF8 + 8'(n);
    bit_wdata = v;
    bit_wr    = 1'b1;
    tick();
    bit_wr = 1'b0;
  endtask
  task automatic brd(input int n, input logic exp);
    tick();
    bit_addr = 8'hF8 + 8'(n);
    bit_rd   = 1'b1;
    tick();
    bit_rd = 1'b0;
    check({7'h00, bit_rdata}, {7'h00, exp});
  endtask
  task automatic do_reset(input int c);
    rstn = 1'b0;
    repeat (c) tick();
    rstn = 1'b1;
    tick();
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdc(8'hFF, 8'h00);
    rdc(8'hF8, 8'h00);
    rdc(8'hF5, 8'h00);
    check({cal_out_oe, gpio_en, bctl_en, irq2_en, irq1_en, dc_low_sw, sw_off,
           cal_out}, 8'h40);
    wr(8'h80, 8'h5A);
    rdc(8'h80, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_lock();
    int v;
    wr(8'hFF, 8'h0F);
    rdc(8'hFF, 8'h00);
    wr(8'hC1, 8'hEA);
    for (v = 0; v < 16; v++) begin
      wr(8'hFF, 8'(v));
      rdc(8'hFF, 8'(v));
      check({4'h0, gpio_en, bctl_en, irq2_en, irq1_en}, {4'h0, v[2:1] == 2'b00,
            v[2:1] == 2'b01, v[3:2] == 2'b11, v[0]});
    end
    wr(8'hC1, 8'h00);
    wr(8'hFF, 8'h00);
    rdc(8'hFF, 8'h0F);
    $display("test lock done");
  endtask
  task automatic t_cal();
    int s, n, k;
    wr(8'hC1, 8'hEA);
    for (s = 0; s < 4; s++) begin
      wr(8'hFF, 8'h80 | 8'(s << 5));
      repeat (2) tick();
      n = 0;
      k = 0;
      while (cal_out !== 1'b1 && k < 100) begin
        tick();
        k++;
      end
      while (cal_out === 1'b1 && n < 100) begin
        tick();
        n++;
      end
      check(8'(n), 8'(HALF[s]));
      check({7'h00, cal_out_oe}, 8'h01);
    end
    wr(8'hFF, 8'h00);
    repeat (3) tick();
    check({6'h00, cal_out_oe, cal_out}, 8'h00);
    wr(8'hC1, 8'h00);
    $display("test calibration done");
  endtask
  task automatic t_policy();
    int p;
    for (p = 0; p < 4; p++) begin
      wr(8'hF5, 8'(p));
      rdc(8'hF5, 8'(p));
      check({6'h00, dc_low_sw, sw_off}, {6'h00, p == 1, p >= 2});
    end
    $display("test policy done");
  endtask
  task automatic t_events();
    int i, e;
    logic [7:0] x;
    for (e = 0; e < 2; e++) begin
      wr(8'hEC, (e == 1) ? 8'hFF : 8'h00);
      rdc(8'hEC, (e == 1) ? 8'hAF : 8'h00);
      for (i = 0; i < 7; i++) begin
        x = (8'h01 << FLAG[i]) | ((i == 1) ? 8'h80 : 8'h00) | ((e == 1) ? 8'h40 : 8'h00);
        tick();
        ev[i] = 1'b1;
        repeat (4) tick();
        ev[i] = 1'b0;
        repeat (5) tick();
        rdc(8'hF8, x);
        wr(8'hF8, 8'h00);
        rdc(8'hF8, 8'h00);
      end
    end
    wr(8'hEC, 8'h00);
    $display("test events done");
  endtask
  task automatic t_bits();
    int n;
    for (n = 0; n < 8; n++) begin
      if (n != 4) begin
        bwr(n, 1'b1);
        brd(n, 1'b1);
        bwr(n, 1'b0);
        brd(n, 1'b0);
      end
    end
    brd(4, 1'b0);
    bwr(7, 1'b1);
    bwr(0, 1'b1);
    rdc(8'hF8, 8'h81);
    wr(8'hF8, 8'h00);
    $display("test bit access done");
  endtask

  initial begin
    do_reset(16);
    t_reset();
    t_lock();
    t_cal();
    t_policy();
    t_events();
    t_bits();
    wr(8'hF5, 8'h03);
    do_reset(2);
    rdc(8'hF5, 8'h00);
    end_of_test();
  end
endmodule // tb_pmcfg_regs
`default_nettype wire
